// ---- rtl/pcs_chan_clk_sel.sv ----
// pwm channel clock select block: axi4-lite registers, prescalers,
// eight pwm channels each fed by clock a/sa or b/sb
// assumes: single clock aclk, synchronous active-low reset aresetn
//
// Functional notes
// - select bits writable any time, never locked
// - select change acts immediately, pulses may distort
// - unimplemented channel bits ignore writes, read zero
// - channels 0,1,4,5: 0 picks A/SA, 1 B/SB
// - channels 2,3,6,7: 0 picks B/SB, 1 A/SA
// - select bit n steers channel n only
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_chan_clk_sel
  import pcs_pkg::*;
#(
  parameter logic [7:0] CHAN_IMPL = `PCS_CHAN_IMPL  // implemented channels
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // axi4-lite slave
  input  wire pcs_axi_req_s axi_req,
  output pcs_axi_rsp_s      axi_rsp,
  // pwm outputs
  output logic [7:0]        pwm_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  en_r;           // channel enables
  logic [7:0]  pre_r;          // a and b prescale exponents
  logic [7:0]  sel_r;          // channel_clock_source_select
  logic [7:0]  scaled_r;       // 1 = use scaled clock
  logic [7:0]  scl_a_r;        // sa divide of a
  logic [7:0]  scl_b_r;        // sb divide of b
  logic [7:0]  period_r;       // shared period
  logic [7:0]  duty_r [8];     // per-channel duty

  // ----------------------------------------------------------------
  // bus state
  // ----------------------------------------------------------------
  logic        aw_hold_r;      // write address held
  logic        w_hold_r;       // write data held
  logic [5:0]  widx_r;         // held write index
  logic [7:0]  wbyte_r;        // held low data byte
  logic        wlane_r;        // low byte lane strobe
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  // handshake terms
  logic        aw_take;        // address taken this edge
  logic        w_take;         // data taken this edge
  logic        wr_go;          // both halves held, commit
  logic        ar_take;        // read address taken
  logic        aw_hold_nxt;
  logic        w_hold_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;
  logic        wr_hit;         // write index is mapped
  logic [5:0]  ridx;           // read index
  logic [7:0]  rd_byte;        // read mux result
  logic        rd_hit;         // read index is mapped

  // per-channel state
  pcs_ticks_s  ticks;          // prescaled ticks
  logic [7:0]  chan_tick;      // tick each channel sees
  logic [7:0]  chan_src_a;     // 1 = channel on a/sa
  localparam logic [7:0] REV_MASK = `PCS_REV_MASK;  // channels with reversed select

  // ----------------------------------------------------------------
  // write channel handshake
  // ----------------------------------------------------------------
  // address and data may arrive in either order; the response waits
  // for both, and only one write is open at a time
  always_comb begin
    aw_take     = axi_req.awvalid && awready_r;
    w_take      = axi_req.wvalid && wready_r;
    wr_go       = aw_hold_r && w_hold_r;
    aw_hold_nxt = aw_hold_r ? !wr_go : aw_take;
    w_hold_nxt  = w_hold_r ? !wr_go : w_take;
    bvalid_nxt  = bvalid_r ? !axi_req.bready : wr_go;
    ar_take     = axi_req.arvalid && arready_r;
    rvalid_nxt  = rvalid_r ? !axi_req.rready : ar_take;
  end

  // holding flops for address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      widx_r    <= '0;
      wbyte_r   <= '0;
      wlane_r   <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      if (aw_take) begin
        widx_r <= axi_req.awaddr[7:2];  // low bits ignored
      end
      if (w_take) begin
        wbyte_r <= axi_req.wdata[7:0];
        wlane_r <= axi_req.wstrb[0];
      end
    end
  end

  // ready and response flops; each ready drops while its own half is held or a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `PCS_RESP_OKAY;
    end else begin
      awready_r <= !aw_hold_nxt && !bvalid_nxt;
      wready_r  <= !w_hold_nxt && !bvalid_nxt;
      bvalid_r  <= bvalid_nxt;
      if (wr_go) begin
        bresp_r <= wr_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  always_comb begin
    if (widx_r == `PCS_IDX_EN || widx_r == `PCS_IDX_PRE) begin
      wr_hit = 1'b1;
    end else if (widx_r == `PCS_IDX_CLKSEL || widx_r == `PCS_IDX_SCALED) begin
      wr_hit = 1'b1;
    end else if (widx_r == `PCS_IDX_SCL_A || widx_r == `PCS_IDX_SCL_B) begin
      wr_hit = 1'b1;
    end else if (widx_r == `PCS_IDX_PERIOD || widx_r == `PCS_IDX_SRC_STAT) begin
      wr_hit = 1'b1;  // status write is accepted and dropped
    end else if (widx_r[5:3] == `PCS_DUTY_GRP) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // clock select register: no lock or mode gates the write, and
  // bits of absent channels are masked so they stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= `PCS_RST_BYTE;
    end else if (wr_go && wlane_r && widx_r == `PCS_IDX_CLKSEL) begin
      sel_r <= wbyte_r & CHAN_IMPL;
    end
  end

  // control registers of the channels and prescalers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r     <= `PCS_RST_BYTE;
      pre_r    <= `PCS_RST_BYTE;
      scaled_r <= `PCS_RST_BYTE;
      scl_a_r  <= `PCS_RST_BYTE;
      scl_b_r  <= `PCS_RST_BYTE;
      period_r <= `PCS_RST_PERIOD;
    end else if (wr_go && wlane_r) begin
      if (widx_r == `PCS_IDX_EN) begin
        en_r <= wbyte_r & CHAN_IMPL;
      end else if (widx_r == `PCS_IDX_PRE) begin
        pre_r <= wbyte_r;
      end else if (widx_r == `PCS_IDX_SCALED) begin
        scaled_r <= wbyte_r & CHAN_IMPL;
      end else if (widx_r == `PCS_IDX_SCL_A) begin
        scl_a_r <= wbyte_r;
      end else if (widx_r == `PCS_IDX_SCL_B) begin
        scl_b_r <= wbyte_r;
      end else if (widx_r == `PCS_IDX_PERIOD) begin
        period_r <= wbyte_r;
      end
    end
  end

  // duty registers, indexed by the low index bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        duty_r[i] <= `PCS_RST_BYTE;
      end
    end else if (wr_go && wlane_r && widx_r[5:3] == `PCS_DUTY_GRP) begin
      duty_r[widx_r[2:0]] <= wbyte_r;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb begin
    ridx   = axi_req.araddr[7:2];
    rd_hit = 1'b1;
    if (ridx == `PCS_IDX_EN) begin
      rd_byte = en_r;
    end else if (ridx == `PCS_IDX_PRE) begin
      rd_byte = pre_r;
    end else if (ridx == `PCS_IDX_CLKSEL) begin
      rd_byte = sel_r & CHAN_IMPL;
    end else if (ridx == `PCS_IDX_SCALED) begin
      rd_byte = scaled_r;
    end else if (ridx == `PCS_IDX_SCL_A) begin
      rd_byte = scl_a_r;
    end else if (ridx == `PCS_IDX_SCL_B) begin
      rd_byte = scl_b_r;
    end else if (ridx == `PCS_IDX_PERIOD) begin
      rd_byte = period_r;
    end else if (ridx == `PCS_IDX_SRC_STAT) begin
      rd_byte = chan_src_a & CHAN_IMPL;  // live family per channel
    end else if (ridx[5:3] == `PCS_DUTY_GRP) begin
      rd_byte = duty_r[ridx[2:0]];
    end else begin
      rd_byte = `PCS_RST_BYTE;
      rd_hit  = 1'b0;
    end
  end

  // read handshake: data one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= `PCS_RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_take) begin
        rdata_r <= {24'h000000, rd_byte};
        rresp_r <= rd_hit ? `PCS_RESP_OKAY : `PCS_RESP_SLVERR;
      end
    end
  end

  assign axi_rsp = '{awready: awready_r, wready: wready_r, bvalid: bvalid_r,
                     bresp: bresp_r, arready: arready_r, rvalid: rvalid_r,
                     rdata: rdata_r, rresp: rresp_r};

  // ----------------------------------------------------------------
  // prescalers: a and b divide aclk by 2^n, sa and sb divide again
  // ----------------------------------------------------------------
  pcs_tick_div u_div_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_en   (1'b1),
    .div     (8'(`PCS_ONE_BYTE << pre_r[`PCS_PRE_A_F])),
    .tick    (ticks.a)
  );

  pcs_tick_div u_div_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_en   (1'b1),
    .div     (8'(`PCS_ONE_BYTE << pre_r[`PCS_PRE_B_F])),
    .tick    (ticks.b)
  );

  pcs_tick_div u_div_sa (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_en   (ticks.a),
    .div     (scl_a_r),
    .tick    (ticks.sa)
  );

  pcs_tick_div u_div_sb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .in_en   (ticks.b),
    .div     (scl_b_r),
    .tick    (ticks.sb)
  );

  // ----------------------------------------------------------------
  // channels; bit n of the enable, select and scaled registers feeds channel n
  // ----------------------------------------------------------------
  for (genvar n = 0; n < 8; n++) begin : g_chan
    pcs_chan #(
      .REVERSED (REV_MASK[n])
    ) u_chan (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ticks      (ticks),
      .sel_bit    (sel_r[n]),
      .use_scaled (scaled_r[n]),
      .en         (en_r[n]),
      .period     (period_r),
      .duty       (duty_r[n]),
      .tick       (chan_tick[n]),
      .src_a      (chan_src_a[n]),
      .cnt        (),
      .pwm        (pwm_out[n])
    );
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_sel_write_any: assert property (
    (wr_go && wlane_r && widx_r == `PCS_IDX_CLKSEL)
      |=> sel_r == ($past(wbyte_r) & CHAN_IMPL))
    else $error("select write did not land");

  a_unimpl_zero: assert property (
    (ar_take && ridx == `PCS_IDX_CLKSEL) |=> rvalid_r
      && (rdata_r[7:0] & ~CHAN_IMPL) == 8'h00 && rdata_r[7:0] == $past(sel_r))
    else $error("absent channel select bit read nonzero");

  a_bit_per_chan: assert property (
    chan_src_a == (~sel_r ^ REV_MASK))
    else $error("select bit steers wrong channel");

  a_switch_now: assert property (
    (wr_go && wlane_r && widx_r == `PCS_IDX_CLKSEL && en_r[1])
      |=> chan_src_a[1] == !$past(wbyte_r[1]))
    else $error("select change delayed");

  c_sel_write: cover property (
    wr_go && wlane_r && widx_r == `PCS_IDX_CLKSEL);
  c_chan6_on_a: cover property (en_r[6] && sel_r[6] && chan_tick[6]);
  c_unmapped_read: cover property (rvalid_r && rresp_r == `PCS_RESP_SLVERR);

endmodule // pcs_chan_clk_sel

// ---- rtl/pcs_regs.svh ----
// register map and constants of the pwm channel clock select block
// assumes: included by bare name wherever offsets or reset values are needed
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCS_IDX_EN        6'h00
`define PCS_IDX_PRE       6'h02
`define PCS_IDX_CLKSEL    6'h06
`define PCS_IDX_SCALED    6'h08
`define PCS_IDX_SCL_A     6'h09
`define PCS_IDX_SCL_B     6'h0a
`define PCS_IDX_PERIOD    6'h0b
`define PCS_IDX_SRC_STAT  6'h0c
// duty registers occupy indices 0x10..0x17, one per channel
`define PCS_DUTY_GRP      3'h2

// ----------------------------------------------------------------
// fields, reset values, masks
// ----------------------------------------------------------------
`define PCS_PRE_A_F       2:0
`define PCS_PRE_B_F       6:4
`define PCS_RST_BYTE      8'h00
`define PCS_RST_PERIOD    8'hff
`define PCS_CHAN_IMPL     8'hff
`define PCS_REV_MASK      8'hcc
`define PCS_ONE_BYTE      8'h01
`define PCS_RESP_OKAY     2'h0
`define PCS_RESP_SLVERR   2'h2

`endif

// ---- rtl/pcs_pkg.sv ----
// types shared by the pwm channel clock select block
// assumes: compiled before every module of the block
package pcs_pkg;

  // ----------------------------------------------------------------
  // axi4-lite request and response bundles
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } pcs_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcs_axi_rsp_s;

  // prescaled clock ticks: a, scaled a, b, scaled b
  typedef struct packed {
    logic a;
    logic sa;
    logic b;
    logic sb;
  } pcs_ticks_s;

  // clock family chosen by one channel
  typedef enum logic {PCS_SRC_A, PCS_SRC_B} pcs_src_e;

endpackage

// ---- rtl/pcs_tick_div.sv ----
// tick divider: one-cycle pulse every div input enables (div 0 = 256)
// assumes: in_en is a one-cycle enable on aclk
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_tick_div (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // rate control
  input  wire logic       in_en,
  input  wire logic [7:0] div,
  // divided tick
  output logic            tick
);

  logic [7:0] cnt_r;  // enables seen in this period

  // ----------------------------------------------------------------
  // counter; a shrinking div lets the count wrap once, never hang
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (in_en) begin
        if (cnt_r == 8'(div - `PCS_ONE_BYTE)) begin
          cnt_r <= '0;
          tick  <= 1'b1;
        end else begin
          cnt_r <= 8'(cnt_r + `PCS_ONE_BYTE);
        end
      end
    end
  end

endmodule // pcs_tick_div

// ---- rtl/pcs_chan.sv ----
// one pwm channel: clock family pick, counter and output
// assumes: ticks are one-cycle enables on aclk
`timescale 1ns/1ps
`include "pcs_regs.svh"
module pcs_chan
  import pcs_pkg::*;
#(
  parameter bit REVERSED = 1'b0  // select bit encoding reversed
) (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // prescaled ticks
  input  wire pcs_ticks_s ticks,
  // channel controls
  input  wire logic       sel_bit,
  input  wire logic       use_scaled,
  input  wire logic       en,
  input  wire logic [7:0] period,
  input  wire logic [7:0] duty,
  // channel state
  output logic            tick,
  output logic            src_a,
  output logic [7:0]      cnt,
  output logic            pwm
);

  pcs_src_e src;  // family chosen right now

  // ----------------------------------------------------------------
  // source pick; purely combinational so a new select acts at once
  // ----------------------------------------------------------------
  always_comb begin
    src   = (sel_bit ^ REVERSED) ? PCS_SRC_B : PCS_SRC_A;
    src_a = (src == PCS_SRC_A);
    // plain or scaled version is a separate choice
    if (src_a) begin
      tick = use_scaled ? ticks.sa : ticks.a;
    end else begin
      tick = use_scaled ? ticks.sb : ticks.b;
    end
  end

  // ----------------------------------------------------------------
  // counter runs 0..period on chosen ticks only, no period sync
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= (cnt == period) ? '0 : 8'(cnt + `PCS_ONE_BYTE);
    end
  end

  // output high while count is below duty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm <= 1'b0;
    end else begin
      pwm <= en && (cnt < duty);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_plain_enc: assert property (
    !REVERSED |-> tick == (sel_bit ? (use_scaled ? ticks.sb : ticks.b)
                                   : (use_scaled ? ticks.sa : ticks.a)))
    else $error("plain channel clock family wrong");

  a_rev_enc: assert property (
    REVERSED |-> tick == (sel_bit ? (use_scaled ? ticks.sa : ticks.a)
                                  : (use_scaled ? ticks.sb : ticks.b)))
    else $error("reversed channel clock family wrong");

  a_cnt_on_tick: assert property (
    (en && !tick) |=> $stable(cnt))
    else $error("counter moved without its tick");

  a_cnt_advance: assert property (
    (en && tick && cnt != period) |=> cnt == 8'($past(cnt) + `PCS_ONE_BYTE))
    else $error("counter missed its tick");

endmodule // pcs_chan

// ---- tb/test_pwm_channel_clock_select.sv ----
// testbench of the pwm channel clock select block: axi4-lite register access,
// clock family steering per channel, unimplemented channel bits
// assumes: pcs_pkg and pcs_regs.svh compiled first, aclk at 20 mhz
`timescale 1ns/1ps
`include "pcs_regs.svh"
module test_pwm_channel_clock_select
  import pcs_pkg::*;
();
  // ----------------------------------------------------------------
  // addresses and expectations
  // ----------------------------------------------------------------
  localparam logic [7:0] A_EN   = {`PCS_IDX_EN, 2'b00};       // channel enable
  localparam logic [7:0] A_PRE  = {`PCS_IDX_PRE, 2'b00};      // prescale exponents
  localparam logic [7:0] A_SEL  = {`PCS_IDX_CLKSEL, 2'b00};   // clock source select
  localparam logic [7:0] A_PER  = {`PCS_IDX_PERIOD, 2'b00};   // counter period
  localparam logic [7:0] A_STAT = {`PCS_IDX_SRC_STAT, 2'b00}; // family status
  localparam logic [7:0] A_SCL  = {`PCS_IDX_SCALED, 2'b00};   // scaled clock select
  localparam logic [7:0] A_SCLA = {`PCS_IDX_SCL_A, 2'b00};    // sa divisor
  localparam logic [7:0] A_DUTY = 8'h40;                      // duty of channel 0
  localparam logic [7:0] A_HOLE = 8'h04;                      // unmapped word
  localparam logic [7:0] REV_CH = 8'hcc;                      // channels 2,3,6,7
  localparam logic [1:0] OK     = 2'h0;                       // okay response
  localparam logic [1:0] SLV    = 2'h2;                       // slave error

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic         aclk;       // bus clock
  logic         aresetn;    // synchronous reset, active low
  pcs_axi_req_s req [2];    // requests: full block, block with 6 channels
  pcs_axi_rsp_s rsp [2];    // responses
  logic [7:0]   pwm [2];    // channel outputs
  logic [7:0]   v;          // pattern under test
  logic [7:0]   a_val;      // select value putting one channel on a
  int           n;          // toggle count
  int           n_fail;     // mismatches
  int           num_checks; // comparisons

  // ----------------------------------------------------------------
  // design instances
  // ----------------------------------------------------------------
  pcs_chan_clk_sel dut (
    .aclk    (aclk),
    .aresetn (aresetn),
    .axi_req (req[0]),
    .axi_rsp (rsp[0]),
    .pwm_out (pwm[0])
  );

  // channels 6 and 7 absent, so their select bits must stay dead
  pcs_chan_clk_sel #(.CHAN_IMPL(8'h3f)) dut_part (
    .aclk    (aclk),
    .aresetn (aresetn),
    .axi_req (req[1]),
    .axi_rsp (rsp[1]),
    .pwm_out (pwm[1])
  );

  // clock: 50 ns period
  always #25 aclk = ~aclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare and count; mismatch printed at once
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // axi write: address and data offered together, each released when taken
  task wr_chk(input int u, input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    req[u].awaddr  <= a;
    req[u].wdata   <= {24'h0, d};
    req[u].wstrb   <= 4'hf;
    req[u].awvalid <= 1'b1;
    req[u].wvalid  <= 1'b1;
    req[u].bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && rsp[u].awready === 1'b1) begin
        aw_ok = 1'b1;
        req[u].awvalid <= 1'b0;
      end
      if (!w_ok && rsp[u].wready === 1'b1) begin
        w_ok = 1'b1;
        req[u].wvalid <= 1'b0;
      end
    end
    // bready stays up until the response is seen
    do @(posedge aclk); while (rsp[u].bvalid !== 1'b1);
    req[u].bready <= 1'b0;
    chk({30'h0, rsp[u].bresp}, {30'h0, er});
    // spare edge so the next request never reassigns in this step
    @(posedge aclk);
  endtask

  // axi read, compares data and response
  task rd_chk(input int u, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    req[u].araddr  <= a;
    req[u].arvalid <= 1'b1;
    req[u].rready  <= 1'b1;
    do @(posedge aclk); while (rsp[u].arready !== 1'b1);
    req[u].arvalid <= 1'b0;
    do @(posedge aclk); while (rsp[u].rvalid !== 1'b1);
    req[u].rready <= 1'b0;
    chk(rsp[u].rdata, ed);
    chk({30'h0, rsp[u].rresp}, {30'h0, er});
    @(posedge aclk);
  endtask

  // count output changes of channel c over a number of edges
  task count(input int c, input int cyc);
    logic prev;
    n    = 0;
    prev = pwm[0][c];
    repeat (cyc) begin
      @(posedge aclk);
      if (pwm[0][c] !== prev) n = n + 1;
      prev = pwm[0][c];
    end
  endtask

  // verdict and end of run
  task summarize();
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    aclk       = 1'b0;
    aresetn    = 1'b0;
    req[0]     = '0;
    req[1]     = '0;
    n_fail     = 0;
    num_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // after reset select is clear: plain channels on a, reversed on b
    rd_chk(0, A_SEL, 32'h0, OK);
    rd_chk(0, A_STAT, {24'h0, ~REV_CH}, OK);
    // walking one, then all ones: each bit steers its own channel only
    for (int i = 0; i <= 8; i++) begin
      v = (i == 8) ? 8'hff : 8'h01 << i;
      wr_chk(0, A_SEL, v, OK);
      rd_chk(0, A_SEL, {24'h0, v}, OK);
      rd_chk(0, A_STAT, {24'h0, (v & REV_CH) | (~v & ~REV_CH)}, OK);
    end
    // unmapped word refused
    wr_chk(0, A_HOLE, 8'h5a, SLV);
    rd_chk(0, A_HOLE, 32'h0, SLV);
    // absent channels: writes ignored, reads zero
    wr_chk(1, A_SEL, 8'hff, OK);
    rd_chk(1, A_SEL, 32'h3f, OK);
    chk({24'h0, pwm[1]}, 32'h0);
    // a ticks every cycle, b every 128: the active family shows in the toggle rate
    wr_chk(0, A_PRE, 8'h70, OK);
    wr_chk(0, A_PER, 8'h0f, OK);
    for (int c = 0; c < 8; c++) begin
      a_val = REV_CH & (8'h01 << c);
      wr_chk(0, A_DUTY + 8'(4 * c), 8'h08, OK);
      wr_chk(0, A_SEL, a_val, OK);
      wr_chk(0, A_EN, 8'h01 << c, OK);
      count(c, 40);
      chk({31'h0, n >= 2}, 32'h1);
      // switch to b mid-period: counter nearly frozen
      wr_chk(0, A_SEL, a_val ^ (8'h01 << c), OK);
      count(c, 64);
      chk({31'h0, n <= 2}, 32'h1);
      // back to a: acts at once, long before the b period would end
      wr_chk(0, A_SEL, a_val, OK);
      count(c, 24);
      chk({31'h0, n >= 1}, 32'h1);
      chk({24'h0, pwm[0] & ~(8'h01 << c)}, 32'h0);
      wr_chk(0, A_EN, 8'h00, OK);
    end
    // channel 0 on sa (one tick per 64 a ticks), then on a: plain or scaled is separate
    wr_chk(0, A_SEL, 8'h00, OK);
    wr_chk(0, A_SCLA, 8'h40, OK);
    wr_chk(0, A_SCL, 8'h01, OK);
    wr_chk(0, A_EN, 8'h01, OK);
    count(0, 64);
    chk({31'h0, n <= 2}, 32'h1);
    wr_chk(0, A_SCL, 8'h00, OK);
    count(0, 24);
    chk({31'h0, n >= 1}, 32'h1);
    wr_chk(0, A_EN, 8'h00, OK);
    summarize();
  end

  // watchdog: whole sequence needs about 1500 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail = n_fail + 1;
    summarize();
  end

endmodule // test_pwm_channel_clock_select
